// *** hdl/sfwp_pkg.sv ***
// constants, command codes, status field positions and types for the
// serial flash write-protect block.
// assumes a 100 MHz system clock and a 1 MB array of 16 blocks of 64 KB.
package sfwp_pkg;

   // timing
   localparam int CLK_MHZ = 100;
   localparam int POWERUP_WRITE_INHIBIT_US = 5000; // plain default, no figure given
   localparam int INHIBIT_CYCLES = POWERUP_WRITE_INHIBIT_US * CLK_MHZ;
   localparam int OP_BUSY_US = 10; // plain default for every program/erase/status write
   localparam int OP_BUSY_CYCLES = OP_BUSY_US * CLK_MHZ;
   localparam int BUSY_CNT_W = 16;

   // instruction codes
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS1 = 8'h05;
   localparam logic [7:0] CMD_READ_STATUS2 = 8'h35;
   localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
   localparam logic [7:0] CMD_WRITE_STATUS2 = 8'h31;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
   localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] CMD_UNLOCK_REGION = 8'h39;
   localparam logic [7:0] CMD_LOCK_REGION = 8'h36;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
   localparam logic [7:0] CMD_RELEASE_PD = 8'hab;
   localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;

   // status_register_one field positions
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR1_LATCH_BIT = 1;
   localparam int SR1_RANGE_LSB = 2;
   localparam int SR1_TOPBOT_BIT = 5;
   localparam int SR1_GRAN_BIT = 6;
   // status_register_two field positions
   localparam int SR2_LOCK_BIT = 0;
   localparam int SR2_COMPL_BIT = 6;

   // reset values
   localparam logic [2:0] PROTECT_RANGE_RST = 3'h0;
   localparam logic TOP_BOTTOM_RST = 1'b0;
   localparam logic GRANULARITY_RST = 1'b0;
   localparam logic COMPLEMENT_RST = 1'b0;
   localparam logic STATUS_LOCK_RST = 1'b0;

   // lock bit store: 16 bottom sectors, 14 middle blocks, 16 top sectors
   localparam int NUM_LOCKS = 46;
   localparam int LOCK_IDX_W = 6;
   localparam logic [LOCK_IDX_W-1:0] LOCK_MID_BASE = 6'h0f;
   localparam logic [LOCK_IDX_W-1:0] LOCK_TOP_BASE = 6'h1e;
   localparam logic [NUM_LOCKS-1:0] LOCK_RST = {NUM_LOCKS{1'b1}};

   // kind of array operation handed to the array
   typedef enum logic [2:0] {
      SFWP_OP_NONE,
      SFWP_OP_PROGRAM,
      SFWP_OP_SECTOR,
      SFWP_OP_BLOCK,
      SFWP_OP_CHIP
   } sfwp_op_type;

endpackage : sfwp_pkg

// *** hdl/sfwp_lock_bits.sv ***
// per-region lock bit store, one bit per middle block or edge sector.
// assumes synchronous single-cycle commands from the protection core.
`timescale 1ns/1ps
module sfwp_lock_bits
(
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // synchronised reset, active low
   input wire logic set_all_i, // device reset: lock everything
   input wire logic clear_one_i, // unlock one region
   input wire logic lock_one_i, // lock one region
   input wire logic [sfwp_pkg::LOCK_IDX_W-1:0] idx_i, // region index
   output logic [sfwp_pkg::NUM_LOCKS-1:0] locks_o // lock bits, registered
);
   import sfwp_pkg::*;

   logic [NUM_LOCKS-1:0] locks_q;
   logic [NUM_LOCKS-1:0] locks_d;

   // one entry per region; a device reset outranks a single-bit change
   for (genvar g = 0; g < NUM_LOCKS; g++)
   begin : g_entry
      wire hit = (idx_i == LOCK_IDX_W'(g));
      assign locks_d[g] = set_all_i ? 1'b1 : // [R22]
         (hit & clear_one_i) ? 1'b0 : // [R11]
         (hit & lock_one_i) ? 1'b1 : locks_q[g];
   end

   // all bits come up locked
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         locks_q <= LOCK_RST; // [R10]
      else
         locks_q <= locks_d;
   end

   assign locks_o = locks_q;

endmodule : sfwp_lock_bits

// *** hdl/sfwp_core.sv ***
// write-protection and status-register control of a serial flash.
// assumes an spi mode 0 host on cs/sclk/mosi from another clock domain;
// the array itself sits outside and is started by the exec strobe.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] supply reset: no operation, no instruction
// [R02] write commands refused during power-up inhibit
// [R03] write-enable latch starts cleared
// [R04] writes need write-enable latch set first
// [R05] write enable sets latch, read at S1
// [R06] latch cleared by disable, program, erase, status write
// [R07] power-down ignores all but release
// [R08] 14 block and 32 sector lock bits
// [R09] locked region ignores program and erase
// [R10] lock bits all set at power-on
// [R11] unlock instruction 39h clears region lock
// [R12] scheme select chooses range or lock bits
// [R13] busy at S0; only status reads meanwhile
// [R14] busy clears when operation finishes
// [R15] range bits S4..S2 default zero, none protected
// [R16] top/bottom picks start of range
// [R17] granularity: sectors when one, blocks zero
// [R18] complement at S14 inverts selection
// [R19] status lock S8 blocks status writes
// [R20] status write needs lock clear, latch set
// [R21] any protected portion ignores whole command
// [R22] device reset sets all lock bits
// [R23] decode scheme, check target before start
module sfwp_core
#(
   parameter int unsigned INHIBIT_CYCLES_P = sfwp_pkg::INHIBIT_CYCLES // power-up inhibit
)
(
   input wire logic clk_i, // 100 MHz system clock
   input wire logic rstn_i, // supply reset, active low, async
   input wire logic cs_n_i, // chip select pin, active low
   input wire logic sclk_i, // serial clock pin
   input wire logic mosi_i, // serial data in
   input wire logic protect_scheme_select_i, // 1: lock bits, 0: range bits
   output logic miso_o, // serial data out, registered
   output logic miso_oe_n_o, // low while driving miso
   output logic busy_o, // operation in progress
   output logic exec_valid_o, // one-cycle start of array operation
   output sfwp_pkg::sfwp_op_type exec_kind_o, // kind of operation
   output logic [23:0] exec_addr_o // target address
);
   import sfwp_pkg::*;

   // reset release and pin synchronisers
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [2:0] sclk_q;
   logic [2:0] cs_q;
   logic [1:0] mosi_q;

   // frame state
   logic [2:0] bit_cnt_q;
   logic [2:0] byte_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] opcode_q;
   logic [23:0] addr_q;
   logic [7:0] tx_q;
   logic reading_q;
   logic read_sel2_q;
   logic miso_q;

   // device state
   logic wel_q;
   logic pd_q;
   logic rst_en_q;
   logic srl_q;
   logic cmp_q;
   logic tb_q;
   logic sec_q;
   logic [2:0] bp_q;
   logic [BUSY_CNT_W-1:0] busy_cnt_q;
   logic [31:0] inh_cnt_q;
   logic exec_valid_q;
   sfwp_op_type exec_kind_q;
   logic [23:0] exec_addr_q;
   logic [NUM_LOCKS-1:0] locks;

   // the supply reset acts at once; its release is synchronised
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // pins cross two flops; the third stage only feeds edge detection
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q <= 3'h0;
         cs_q <= 3'h7;
         mosi_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk_i};
         cs_q <= {cs_q[1:0], cs_n_i};
         mosi_q <= {mosi_q[0], mosi_i};
      end
   end

   // edges of the sampled link; sclk must be slow enough for this
   wire sel = ~cs_q[1];
   wire cs_fall = ~cs_q[1] & cs_q[2];
   wire cs_rise = cs_q[1] & ~cs_q[2];
   wire sclk_rise = sel & sclk_q[1] & ~sclk_q[2];
   wire sclk_fall = sel & ~sclk_q[1] & sclk_q[2];
   wire [7:0] rx_next = {rx_q[6:0], mosi_q[1]};
   wire byte_done = sclk_rise & (bit_cnt_q == 3'h7);
   wire [7:0] opc_now = (byte_cnt_q == 3'h0) ? rx_next : opcode_q;

   // status images
   wire busy = (busy_cnt_q != '0);
   wire [7:0] sr1 = {1'b0, sec_q, tb_q, bp_q, wel_q, busy}; // [R05] [R13]
   wire [7:0] sr2 = {1'b0, cmp_q, 5'h00, srl_q};
   wire is_rd1 = (opc_now == CMD_READ_STATUS1);
   wire is_rd2 = (opc_now == CMD_READ_STATUS2);
   wire rd_ok = (is_rd1 | is_rd2) & ~pd_q; // [R07]

   // shift register and byte capture on sampled sclk rise
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 3'h0;
         rx_q <= 8'h00;
         opcode_q <= 8'h00;
         addr_q <= 24'h000000;
      end
      else if (cs_fall)
      begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 3'h0;
      end
      else if (sclk_rise)
      begin
         rx_q <= rx_next;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (byte_done && byte_cnt_q != 3'h7)
            byte_cnt_q <= byte_cnt_q + 3'h1;
         if (byte_done && byte_cnt_q == 3'h0)
            opcode_q <= rx_next;
         else if (byte_done && byte_cnt_q <= 3'h3)
            addr_q <= {addr_q[15:0], rx_next};
      end
   end

   // status read: reload each byte so polling sees busy fall
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q <= 8'h00;
         reading_q <= 1'b0;
         read_sel2_q <= 1'b0;
         miso_q <= 1'b0;
      end
      else if (cs_fall || cs_rise)
         reading_q <= 1'b0;
      else if (byte_done && (byte_cnt_q == 3'h0 ? rd_ok : reading_q))
      begin
         reading_q <= 1'b1;
         read_sel2_q <= (byte_cnt_q == 3'h0) ? is_rd2 : read_sel2_q;
         tx_q <= ((byte_cnt_q == 3'h0) ? is_rd2 : read_sel2_q) ? sr2 : sr1; // [R13]
      end
      else if (sclk_fall && reading_q)
      begin
         miso_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // protection range decode, in 4 KB sector units over 256 sectors
   wire [7:0] tgt_sector = addr_q[19:12];
   wire is_pp = (opcode_q == CMD_PAGE_PROGRAM);
   wire is_se = (opcode_q == CMD_SECTOR_ERASE);
   wire is_be = (opcode_q == CMD_BLOCK_ERASE);
   wire is_ce = (opcode_q == CMD_CHIP_ERASE_A) | (opcode_q == CMD_CHIP_ERASE_B);
   wire [7:0] lo_sec = is_ce ? 8'h00 : is_be ? {tgt_sector[7:4], 4'h0} : tgt_sector;
   wire [7:0] hi_sec = is_ce ? 8'hff : is_be ? {tgt_sector[7:4], 4'hf} : tgt_sector;
   wire [8:0] unit = sec_q ? 9'h001 : 9'h010; // [R17]
   wire [8:0] sel_n = (bp_q == 3'h0) ? 9'h000 : // [R15]
      (bp_q == 3'h7) ? 9'h100 :
      (bp_q >= 3'h5) ? (sec_q ? 9'h008 : 9'h100) :
      9'(unit << (bp_q - 3'h1));
   wire [8:0] top_start = 9'h100 - sel_n;
   wire sel_any = tb_q ? ({1'b0, lo_sec} < sel_n) : ({1'b0, hi_sec} >= top_start); // [R16]
   wire sel_all = tb_q ? ({1'b0, hi_sec} < sel_n) : ({1'b0, lo_sec} >= top_start);
   wire prot_range = cmp_q ? ~sel_all : sel_any; // [R18] [R21]

   // lock bit lookup: index is monotonic in sector, so a range maps to a range
   function automatic logic [LOCK_IDX_W-1:0] lock_index(input logic [7:0] s);
      logic [LOCK_IDX_W-1:0] r;
      r = LOCK_MID_BASE + LOCK_IDX_W'(s[7:4]);
      if (s[7:4] == 4'h0)
         r = LOCK_IDX_W'(s[3:0]);
      else if (s[7:4] == 4'hf)
         r = LOCK_TOP_BASE + LOCK_IDX_W'(s[3:0]);
      return r;
   endfunction : lock_index

   wire [LOCK_IDX_W-1:0] lo_idx = lock_index(lo_sec);
   wire [LOCK_IDX_W-1:0] hi_idx = lock_index(hi_sec);
   logic [NUM_LOCKS-1:0] in_range;
   for (genvar g = 0; g < NUM_LOCKS; g++)
   begin : g_range
      assign in_range[g] = (LOCK_IDX_W'(g) >= lo_idx) && (LOCK_IDX_W'(g) <= hi_idx);
   end
   wire prot_lock = |(locks & in_range); // [R09] [R21]
   wire protected_tgt = protect_scheme_select_i ? prot_lock : prot_range; // [R12] [R23]

   // command acceptance, evaluated when chip select rises on a byte boundary
   wire inhibit = (inh_cnt_q != 32'(INHIBIT_CYCLES_P));
   wire frame_ok = cs_rise & (bit_cnt_q == 3'h0) & (byte_cnt_q != 3'h0);
   wire live = frame_ok & ~busy & ~pd_q; // [R07] [R13]
   wire wr_ok = live & wel_q & ~inhibit; // [R02] [R04]
   wire one_byte = (byte_cnt_q == 3'h1);
   wire do_wren = live & ~inhibit & one_byte & (opcode_q == CMD_WRITE_ENABLE); // [R02]
   wire do_wrdi = live & one_byte & (opcode_q == CMD_WRITE_DISABLE);
   wire st_len1 = (opcode_q == CMD_WRITE_STATUS) & (byte_cnt_q == 3'h2);
   wire st_len2 = (opcode_q == CMD_WRITE_STATUS) & (byte_cnt_q == 3'h3);
   wire st2_only = (opcode_q == CMD_WRITE_STATUS2) & (byte_cnt_q == 3'h2);
   wire do_wrsr = wr_ok & ~srl_q & (st_len1 | st_len2 | st2_only); // [R19] [R20]
   wire array_cmd = (is_pp & byte_cnt_q >= 3'h5) | ((is_se | is_be) & byte_cnt_q == 3'h4) |
      (is_ce & one_byte);
   wire do_array = wr_ok & array_cmd & ~protected_tgt; // [R21] [R23]
   wire lock_len = (byte_cnt_q == 3'h4);
   wire do_unlock = wr_ok & lock_len & (opcode_q == CMD_UNLOCK_REGION); // [R11]
   wire do_lock = wr_ok & lock_len & (opcode_q == CMD_LOCK_REGION);
   wire do_pd = live & one_byte & (opcode_q == CMD_POWER_DOWN);
   wire do_rpd = frame_ok & ~busy & one_byte & (opcode_q == CMD_RELEASE_PD); // [R07]
   wire do_rsten = live & one_byte & (opcode_q == CMD_RESET_ENABLE);
   wire do_reset = live & one_byte & rst_en_q & (opcode_q == CMD_RESET);
   sfwp_op_type kind_d;
   assign kind_d = is_pp ? SFWP_OP_PROGRAM : is_se ? SFWP_OP_SECTOR :
      is_be ? SFWP_OP_BLOCK : is_ce ? SFWP_OP_CHIP : SFWP_OP_NONE;

   // power-up write inhibit counter
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         inh_cnt_q <= 32'h0; // [R01]
      else if (inhibit)
         inh_cnt_q <= inh_cnt_q + 32'h1; // [R02]
   end

   // write enable latch, power-down and reset-enable state
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wel_q <= 1'b0; // [R03]
         pd_q <= 1'b0;
         rst_en_q <= 1'b0;
      end
      else if (do_reset)
      begin
         wel_q <= 1'b0;
         pd_q <= 1'b0;
         rst_en_q <= 1'b0;
      end
      else if (frame_ok)
      begin
         if (do_wren)
            wel_q <= 1'b1; // [R05]
         else if (do_wrdi | do_wrsr | do_array | do_unlock | do_lock)
            wel_q <= 1'b0; // [R06]
         if (do_pd)
            pd_q <= 1'b1; // [R07]
         else if (do_rpd)
            pd_q <= 1'b0;
         rst_en_q <= do_rsten;
      end
   end

   // status fields; the lock bit stays set until the next supply reset
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bp_q <= PROTECT_RANGE_RST; // [R15]
         tb_q <= TOP_BOTTOM_RST; // [R16]
         sec_q <= GRANULARITY_RST; // [R17]
         cmp_q <= COMPLEMENT_RST; // [R18]
         srl_q <= STATUS_LOCK_RST; // [R19]
      end
      else if (do_wrsr)
      begin
         if (!st2_only)
         begin
            bp_q <= 3'((st_len2 ? addr_q[15:8] : addr_q[7:0]) >> SR1_RANGE_LSB);
            tb_q <= st_len2 ? addr_q[8 + SR1_TOPBOT_BIT] : addr_q[SR1_TOPBOT_BIT];
            sec_q <= st_len2 ? addr_q[8 + SR1_GRAN_BIT] : addr_q[SR1_GRAN_BIT];
         end
         if (!st_len1)
         begin
            cmp_q <= addr_q[SR2_COMPL_BIT];
            srl_q <= addr_q[SR2_LOCK_BIT]; // [R19]
         end
      end
   end

   // busy timer and array start strobe; a device reset clears the timer but is only accepted while not busy
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_cnt_q <= '0;
         exec_valid_q <= 1'b0;
         exec_kind_q <= SFWP_OP_NONE;
         exec_addr_q <= 24'h000000;
      end
      else
      begin
         exec_valid_q <= do_array;
         if (do_reset)
            busy_cnt_q <= '0;
         else if (do_array || do_wrsr)
            busy_cnt_q <= BUSY_CNT_W'(OP_BUSY_CYCLES); // [R13]
         else if (busy)
            busy_cnt_q <= busy_cnt_q - 1'b1; // [R14]
         if (do_array)
         begin
            exec_kind_q <= kind_d;
            exec_addr_q <= addr_q;
         end
      end
   end

   // lock bits; the index comes from the addressed region
   sfwp_lock_bits u_locks
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .set_all_i(do_reset), // [R22]
      .clear_one_i(do_unlock),
      .lock_one_i(do_lock),
      .idx_i(lo_idx), // [R08]
      .locks_o(locks)
   );

   assign miso_o = miso_q;
   assign miso_oe_n_o = ~(reading_q & sel);
   assign busy_o = busy;
   assign exec_valid_o = exec_valid_q;
   assign exec_kind_o = exec_kind_q;
   assign exec_addr_o = exec_addr_q;

endmodule : sfwp_core

// *** tb/sfwp_core_chk.sv ***
// port assertions for the flash write-protect core.
// assumes one clock domain, bound into sfwp_core.
`timescale 1ns/1ps
module sfwp_core_chk
#(
   parameter int unsigned INHIBIT_CYCLES_P = 50 // power-up inhibit
)
(
   input wire logic clk_i, // clock
   input wire logic rstn_i, // reset, active low
   input wire logic cs_n_i, // chip select
   input wire logic sclk_i, // serial clock
   input wire logic mosi_i, // serial in
   input wire logic protect_scheme_select_i, // scheme
   input wire logic miso_o, // serial out
   input wire logic miso_oe_n_o, // out enable
   input wire logic busy_o, // busy
   input wire logic exec_valid_o, // array start
   input wire sfwp_pkg::sfwp_op_type exec_kind_o, // kind
   input wire logic [23:0] exec_addr_o // address
);
   import sfwp_pkg::*;
   logic [31:0] up_cnt_q;
   logic [15:0] busy_cnt_q;

   // counters, since long spans cannot be unrolled as repetitions
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         up_cnt_q <= '0;
         busy_cnt_q <= '0;
      end
      else
      begin
         up_cnt_q <= (&up_cnt_q) ? up_cnt_q : up_cnt_q + 32'h1;
         busy_cnt_q <= busy_o ? busy_cnt_q + 16'h1 : 16'h0;
      end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   // an accepted operation: idle, then start together with busy
   sequence op_launch_s;
      !busy_o ##1 (exec_valid_o && busy_o);
   endsequence
   sequence op_run_s;
      (busy_o && !exec_valid_o) [*8];
   endsequence

   launch_busy_a: assert property (exec_valid_o |-> busy_o && !$past(busy_o))
      else $error("start without fresh busy");
   launch_quiet_a: assert property (op_launch_s |=> op_run_s)
      else $error("busy gap after start");
   busy_span_a: assert property ($fell(busy_o) |-> busy_cnt_q == 16'(OP_BUSY_CYCLES))
      else $error("busy span wrong");
   busy_bound_a: assert property (busy_o |-> busy_cnt_q < 16'(OP_BUSY_CYCLES))
      else $error("busy held too long");
   write_inhibit_a: assert property ($rose(busy_o) |-> up_cnt_q >= INHIBIT_CYCLES_P)
      else $error("write during inhibit");
   exec_kind_a: assert property (exec_valid_o |-> exec_kind_o != SFWP_OP_NONE)
      else $error("start with no kind");
   exec_hold_a: assert property (!exec_valid_o |-> $stable(exec_kind_o)
      && $stable(exec_addr_o))
      else $error("kind or address moved");
   reset_quiet_a: assert property ($rose(rstn_i) |-> !busy_o && !exec_valid_o)
      else $error("activity out of reset");
   deselect_off_a: assert property (cs_n_i [*4] |-> miso_oe_n_o)
      else $error("driving while deselected");
endmodule : sfwp_core_chk

bind sfwp_core sfwp_core_chk #(.INHIBIT_CYCLES_P(INHIBIT_CYCLES_P)) i_sfwp_core_chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .mosi_i(mosi_i),
   .protect_scheme_select_i(protect_scheme_select_i), .miso_o(miso_o),
   .miso_oe_n_o(miso_oe_n_o), .busy_o(busy_o), .exec_valid_o(exec_valid_o),
   .exec_kind_o(exec_kind_o), .exec_addr_o(exec_addr_o));

// *** tb/sfwp_host.sv ***
// spi mode 0 host model for the flash write-protect core.
// assumes the core samples its pins with the 100 MHz clock.
`timescale 1ns/1ps
module sfwp_host
(
   input wire logic clk_i, // clock
   input wire logic miso_i, // serial from core
   input wire logic miso_oe_n_i, // low while core drives
   output logic cs_n_o, // chip select
   output logic sclk_o, // 80 ns serial clock
   output logic mosi_o // serial to core
);
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
   end

   // one frame msb first; sclk stands low outside frames and mosi
   // shows the inverse of its last bit so stale data is never reused
   task automatic xfer(input logic [7:0] q[$], output logic [7:0] rd);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      foreach (q[i])
         for (int b = 7; b >= 0; b--)
         begin
            mosi_o <= q[i][b];
            repeat (4) @(posedge clk_i);
            rd = {rd[6:0], miso_oe_n_i ? 1'bx : miso_i}; // undriven reads unknown
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
         end
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (12) @(posedge clk_i);
   endtask : xfer
endmodule : sfwp_host

// *** tb/tb.sv ***
// self-checking bench for the flash write-protect core.
// assumes sfwp_host on the pins and the bound checker.
`timescale 1ns/1ps
module tb;
   import sfwp_pkg::*;
   localparam int INH = 400; // shortened inhibit
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic scheme = 1'b0;
   logic cs_n, sclk, mosi, miso, miso_oe_n, busy, exec_valid;
   sfwp_op_type exec_kind;
   logic [23:0] exec_addr;
   logic [7:0] rd;
   int fail_count = 0;
   int checked = 0;
   int execs = 0;

   sfwp_core #(.INHIBIT_CYCLES_P(INH)) i_sfwp_core (.clk_i(clk_i), .rstn_i(rstn_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .protect_scheme_select_i(scheme),
      .miso_o(miso), .miso_oe_n_o(miso_oe_n), .busy_o(busy), .exec_valid_o(exec_valid),
      .exec_kind_o(exec_kind), .exec_addr_o(exec_addr));
   sfwp_host i_sfwp_host (.clk_i(clk_i), .miso_i(miso), .miso_oe_n_i(miso_oe_n),
      .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

   always #5 clk_i = ~clk_i;
   // accepted array operations
   always @(posedge clk_i)
      if (exec_valid === 1'b1)
         execs++;

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic cmd(input logic [7:0] op);
      i_sfwp_host.xfer('{op}, rd);
   endtask : cmd

   task automatic status(input logic [7:0] op, input logic [7:0] exp);
      i_sfwp_host.xfer('{op, 8'h00}, rd);
      check("status", {16'h0, exp}, {16'h0, rd});
   endtask : status

   // bounded: a stuck busy must not hang the run
   task automatic wait_idle;
      repeat (1200)
         if (busy !== 1'b0)
            @(posedge clk_i);
   endtask : wait_idle

   task automatic array_op(input logic [7:0] op, input logic [23:0] a, input logic ok);
      int n;
      sfwp_op_type k;
      n = execs;
      k = op == CMD_PAGE_PROGRAM ? SFWP_OP_PROGRAM : op == CMD_SECTOR_ERASE ? SFWP_OP_SECTOR :
         op == CMD_BLOCK_ERASE ? SFWP_OP_BLOCK : SFWP_OP_CHIP;
      if (op == CMD_PAGE_PROGRAM)
         i_sfwp_host.xfer('{op, a[23:16], a[15:8], a[7:0], 8'h5a}, rd);
      else if (k == SFWP_OP_CHIP)
         cmd(op);
      else
         i_sfwp_host.xfer('{op, a[23:16], a[15:8], a[7:0]}, rd);
      check("starts", 24'(ok), 24'(execs - n));
      if (ok)
         check("kind", 24'(k), 24'(exec_kind));
      if (ok && k != SFWP_OP_CHIP)
         check("address", a, exec_addr);
      wait_idle();
   endtask : array_op

   task automatic write_status(input logic [7:0] s1, input logic [7:0] s2);
      cmd(CMD_WRITE_ENABLE);
      i_sfwp_host.xfer('{CMD_WRITE_STATUS, s1, s2}, rd);
      wait_idle();
   endtask : write_status

   task automatic t_power_up;
      cmd(CMD_WRITE_ENABLE);
      status(CMD_READ_STATUS1, 8'h00);
      status(CMD_READ_STATUS2, 8'h00);
      repeat (INH) @(posedge clk_i);
      cmd(CMD_WRITE_ENABLE);
      status(CMD_READ_STATUS1, 8'h02);
      cmd(CMD_WRITE_DISABLE);
      status(CMD_READ_STATUS1, 8'h00);
      array_op(CMD_SECTOR_ERASE, 24'h010000, 1'b0);
   endtask : t_power_up

   task automatic t_kinds;
      logic [7:0] ops [5] = '{CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK_ERASE,
         CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B};
      foreach (ops[i])
      begin
         cmd(CMD_WRITE_ENABLE);
         array_op(ops[i], 24'h030000, 1'b1);
         status(CMD_READ_STATUS1, 8'h00);
      end
   endtask : t_kinds

   task automatic t_busy;
      cmd(CMD_WRITE_ENABLE);
      i_sfwp_host.xfer('{CMD_SECTOR_ERASE, 8'h02, 8'h00, 8'h00}, rd);
      cmd(CMD_WRITE_ENABLE);
      status(CMD_READ_STATUS1, 8'h01);
      wait_idle();
      status(CMD_READ_STATUS1, 8'h00);
   endtask : t_busy

   // range settings: status one, status two, protected and free address
   task automatic t_ranges;
      logic [7:0] s1, s2;
      logic [23:0] p, f;
      logic [63:0] tbl [4] = '{64'h04000f00000e0000, 64'h2400000000010000,
         64'h44000ff0000fe000, 64'h04400e00000f0000};
      foreach (tbl[i])
      begin
         {s1, s2, p, f} = tbl[i];
         write_status(s1, s2);
         status(CMD_READ_STATUS1, s1);
         status(CMD_READ_STATUS2, s2);
         cmd(CMD_WRITE_ENABLE);
         array_op(CMD_BLOCK_ERASE, p, 1'b0);
         array_op(CMD_SECTOR_ERASE, p, 1'b0);
         array_op(CMD_SECTOR_ERASE, f, 1'b1);
      end
      write_status(8'h00, 8'h00);
   endtask : t_ranges

   task automatic t_locks;
      scheme <= 1'b1;
      cmd(CMD_WRITE_ENABLE);
      array_op(CMD_BLOCK_ERASE, 24'h050000, 1'b0);
      i_sfwp_host.xfer('{CMD_UNLOCK_REGION, 8'h05, 8'h00, 8'h00}, rd);
      cmd(CMD_WRITE_ENABLE);
      array_op(CMD_BLOCK_ERASE, 24'h050000, 1'b1);
      // relocking the block must shut it again
      cmd(CMD_WRITE_ENABLE);
      i_sfwp_host.xfer('{CMD_LOCK_REGION, 8'h05, 8'h00, 8'h00}, rd);
      cmd(CMD_WRITE_ENABLE);
      array_op(CMD_BLOCK_ERASE, 24'h050000, 1'b0);
      array_op(CMD_SECTOR_ERASE, 24'h0ff000, 1'b0);
      i_sfwp_host.xfer('{CMD_UNLOCK_REGION, 8'h0f, 8'hf0, 8'h00}, rd);
      cmd(CMD_WRITE_ENABLE);
      array_op(CMD_SECTOR_ERASE, 24'h0fe000, 1'b0);
      array_op(CMD_SECTOR_ERASE, 24'h0ff000, 1'b1);
      cmd(CMD_RESET_ENABLE);
      cmd(CMD_RESET);
      cmd(CMD_WRITE_ENABLE);
      array_op(CMD_SECTOR_ERASE, 24'h0ff000, 1'b0);
      scheme <= 1'b0;
   endtask : t_locks

   task automatic t_power_down;
      // a refused erase leaves the latch set, so clear it first
      cmd(CMD_WRITE_DISABLE);
      cmd(CMD_POWER_DOWN);
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_RELEASE_PD);
      status(CMD_READ_STATUS1, 8'h00);
   endtask : t_power_down

   task automatic t_status_lock;
      cmd(CMD_WRITE_ENABLE);
      i_sfwp_host.xfer('{CMD_WRITE_STATUS2, 8'h01}, rd);
      wait_idle();
      status(CMD_READ_STATUS2, 8'h01);
      write_status(8'h1c, 8'h00);
      status(CMD_READ_STATUS1, 8'h02);
      // supply drop in mid-erase, then the lock must be gone
      i_sfwp_host.xfer('{CMD_SECTOR_ERASE, 8'h03, 8'h00, 8'h00}, rd);
      check("busy", 24'h1, 24'(busy));
      rstn_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check("busy", 24'h0, 24'(busy));
      rstn_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      status(CMD_READ_STATUS2, 8'h00);
   endtask : t_status_lock

   task automatic report_and_stop;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      t_power_up();
      t_kinds();
      t_busy();
      t_ranges();
      t_locks();
      t_power_down();
      t_status_lock();
      report_and_stop();
   end

   // watchdog well beyond the expected run length
   initial
   begin
      repeat (90000) @(posedge clk_i);
      fail_count++;
      report_and_stop();
   end
endmodule : tb
